// [pkg/hmwc_regs.vh]
// register map, field positions, reset values and timing counts of the halt wake-up control
`ifndef HMWC_REGS_VH
`define HMWC_REGS_VH
`define HMWC_IDX_PRESCALER 12'h049
`define HMWC_IDX_CTRL_STAT 12'h04a
`define HMWC_ADDR_PRESCALER 12'h124
`define HMWC_ADDR_CTRL_STAT 12'h128
`define HMWC_BIT_ENABLE 0
`define HMWC_BIT_MEASURE 1
`define HMWC_BIT_FLAG 2
`define HMWC_RST_PRESCALER 8'hff
`define HMWC_RST_CTRL_STAT 8'h00
`define HMWC_PRESCALER_FORBIDDEN 8'h00
`define HMWC_FIXED_DIV 64
`define HMWC_FIXED_DIV_LAST 6'h3f
`define HMWC_STAB_SHORT_CYC 13'h0100
`define HMWC_STAB_LONG_CYC 13'h1000
`define HMWC_CLK_MHZ 25
`define HMWC_PLL_STARTUP_NS 1000
`define HMWC_PLL_STARTUP_CYC ((`HMWC_PLL_STARTUP_NS * `HMWC_CLK_MHZ + 999) / 1000)
`endif

// [design/hmwc_top.v]
// halt, active-halt and timed wake-up halt control with its apb registers
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hmwc_regs.vh"
module hmwc_top (
   input wire clk,
   input wire rst_b,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire halt_exec,
   input wire timebase_irq_enable,
   input wire overflow_irq_enable,
   input wire timer_clock_sel_hi,
   input wire timer_clock_sel_lo,
   input wire watchdog_active,
   input wire watchdog_halt_option,
   input wire pll_enable_option,
   input wire stab_long_select,
   input wire halt_exit_irq,
   input wire wake_reset,
   input wire rc_tick,
   output reg irq_mask_clear,
   output reg watchdog_reset,
   output reg resume_interrupt,
   output reg resume_reset_vector,
   output wire wakeup_irq,
   output wire main_osc_enable,
   output wire cpu_clock_enable,
   output wire periph_clock_enable,
   output wire timer_clock_enable,
   output wire rc_osc_enable,
   output wire rc_capture_route,
   output wire in_active_halt,
   output wire timed_wakeup_halt,
   output wire in_plain_halt
);

   // one-hot mode states
   localparam [5:0] st_run = 6'h01;
   localparam [5:0] st_active = 6'h02;
   localparam [5:0] st_plain = 6'h04;
   localparam [5:0] st_timed = 6'h08;
   localparam [5:0] st_stab = 6'h10;
   localparam [5:0] st_pll = 6'h20;
   // pll start-up rounded up to whole cycles, cut to the delay counter width
   localparam integer pll_cyc_full = `HMWC_PLL_STARTUP_CYC;
   localparam [12:0] pll_cyc = pll_cyc_full[12:0];
   // gate bits: plain, timed, active, oscillator, cpu, peripherals, timer
   localparam [6:0] gates_at_reset = 7'h0f;

   reg [5:0] state;
   reg [5:0] next_state;
   reg [7:0] wakeup_prescaler_value;
   reg timed_wakeup_enable;
   reg rc_measure_enable;
   reg wakeup_flag;
   reg [5:0] fixed_div;
   reg [7:0] presc_cnt;
   reg [12:0] delay_cnt;
   reg wake_by_reset;
   reg [6:0] gate;

   function is_addr;
      input [11:0] a;
      input [11:0] b;
      begin
         is_addr = (a == b);
      end
   endfunction

   // destination of a halt instruction taken in run state
   function [5:0] halt_target;
      input active_ok;
      input wdog_reset;
      input timed_en;
      begin
         if (active_ok) begin
            halt_target = st_active;
         end else if (wdog_reset) begin
            halt_target = st_run;
         end else if (timed_en) begin
            halt_target = st_timed;
         end else begin
            halt_target = st_plain;
         end
      end
   endfunction

   // clock gating and mode indications for a given state
   function [6:0] gates_for;
      input [5:0] s;
      begin
         case (s)
            st_run: begin
               gates_for = 7'h0f;
            end
            st_active: begin
               gates_for = 7'h19;
            end
            st_plain: begin
               gates_for = 7'h40;
            end
            st_timed: begin
               gates_for = 7'h20;
            end
            st_stab: begin
               gates_for = 7'h08;
            end
            st_pll: begin
               gates_for = 7'h08;
            end
            default: begin
               gates_for = 7'h08;
            end
         endcase
      end
   endfunction

   // read view of a register, reserved bits zero
   function [31:0] read_word;
      input [11:0] a;
      input [7:0] ctrl;
      input [7:0] presc;
      begin
         if (is_addr(a, `HMWC_ADDR_CTRL_STAT)) begin
            read_word = {24'h000000, ctrl};
         end else if (is_addr(a, `HMWC_ADDR_PRESCALER)) begin
            read_word = {24'h000000, presc};
         end else begin
            read_word = 32'h00000000;
         end
      end
   endfunction

   // stabilisation length for the selected oscillator start-up
   function [12:0] stab_length;
      input long_sel;
      begin
         if (long_sel) begin
            stab_length = `HMWC_STAB_LONG_CYC;
         end else begin
            stab_length = `HMWC_STAB_SHORT_CYC;
         end
      end
   endfunction

   // last rc tick of the last prescaler step ends the timed halt
   function last_tick;
      input [5:0] div;
      input [7:0] steps;
      input [7:0] limit;
      begin
         last_tick = (div == `HMWC_FIXED_DIV_LAST) & (steps == limit - 8'h01);
      end
   endfunction

   wire bus_write = psel & penable & pwrite;
   wire bus_read = psel & penable & ~pwrite;
   wire hit_presc = is_addr(paddr, `HMWC_ADDR_PRESCALER);
   wire hit_ctrl = is_addr(paddr, `HMWC_ADDR_CTRL_STAT);
   wire [7:0] ctrl_stat_view = {5'h00, wakeup_flag, rc_measure_enable, timed_wakeup_enable};

   wire active_halt_on = timebase_irq_enable |
      (overflow_irq_enable & ~timer_clock_sel_hi & timer_clock_sel_lo);
   wire wdog_halt_reset = watchdog_active & watchdog_halt_option;
   wire [5:0] halt_dest = halt_target(active_halt_on, wdog_halt_reset, timed_wakeup_enable);

   // rc ticks through the fixed divider then the prescaler
   wire div_wrap = rc_tick & (fixed_div == `HMWC_FIXED_DIV_LAST);
   wire awu_expire = (state == st_timed) & rc_tick &
      last_tick(fixed_div, presc_cnt, wakeup_prescaler_value);

   wire [12:0] stab_cyc = stab_length(stab_long_select);
   wire delay_done = (delay_cnt == 13'h0001);

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_presc & ~hit_ctrl;

   always @* begin
      next_state = state;
      case (state)
         st_run: begin
            if (halt_exec) begin
               next_state = halt_dest;
            end
         end
         st_active: begin
            if (wake_reset) begin
               next_state = st_stab;
            end else if (halt_exit_irq) begin
               next_state = st_run;
            end
         end
         st_plain: begin
            if (wake_reset | halt_exit_irq) begin
               next_state = st_stab;
            end
         end
         st_timed: begin
            // exit on reset, interrupt or expiry
            if (wake_reset | halt_exit_irq | awu_expire) begin
               next_state = st_stab;
            end
         end
         st_stab: begin
            if (delay_done) begin
               next_state = (pll_enable_option & ~wake_by_reset) ? st_pll :
                  (pll_enable_option ? st_pll : st_run);
            end
         end
         st_pll: begin
            if (delay_done) begin
               next_state = st_run;
            end
         end
         default: begin
            next_state = st_run;
         end
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= st_run;
         delay_cnt <= 13'h0000;
         wake_by_reset <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state == st_stab && state != st_stab) begin
            delay_cnt <= stab_cyc;
            wake_by_reset <= wake_reset;
         end else if (next_state == st_pll && state != st_pll) begin
            delay_cnt <= pll_cyc;
         end else if (delay_cnt != 13'h0000) begin
            delay_cnt <= delay_cnt - 13'h0001;
         end
      end
   end

   // one-cycle pulses towards the core
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_mask_clear <= 1'b0;
         watchdog_reset <= 1'b0;
         resume_interrupt <= 1'b0;
         resume_reset_vector <= 1'b0;
      end else begin
         irq_mask_clear <= 1'b0;
         watchdog_reset <= 1'b0;
         resume_interrupt <= 1'b0;
         resume_reset_vector <= 1'b0;
         if (state == st_run && halt_exec) begin
            // watchdog reset only when the halt leads nowhere
            if (halt_dest == st_run) begin
               watchdog_reset <= 1'b1;
            end else begin
               irq_mask_clear <= 1'b1;
            end
         end
         if (state == st_active && next_state == st_run) begin
            resume_interrupt <= 1'b1;
         end
         if ((state == st_stab || state == st_pll) && next_state == st_run) begin
            resume_reset_vector <= wake_by_reset;
            resume_interrupt <= ~wake_by_reset;
         end
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fixed_div <= 6'h00;
         presc_cnt <= 8'h00;
      // counters rest outside timed halt so each halt starts a full delay
      end else if (state != st_timed) begin
         fixed_div <= 6'h00;
         presc_cnt <= 8'h00;
      end else if (rc_tick) begin
         fixed_div <= fixed_div + 6'h01;
         if (div_wrap) begin
            presc_cnt <= presc_cnt + 8'h01;
         end
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wakeup_prescaler_value <= `HMWC_RST_PRESCALER;
         timed_wakeup_enable <= 1'b0;
         rc_measure_enable <= 1'b0;
         wakeup_flag <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         if (psel & ~penable) begin
            prdata <= read_word(paddr, ctrl_stat_view, wakeup_prescaler_value);
         end
         if (bus_write & hit_ctrl) begin
            timed_wakeup_enable <= pwdata[`HMWC_BIT_ENABLE];
            rc_measure_enable <= pwdata[`HMWC_BIT_MEASURE];
         end
         if (bus_write & hit_presc & (pwdata[7:0] != `HMWC_PRESCALER_FORBIDDEN)) begin
            wakeup_prescaler_value <= pwdata[7:0];
         end
         // flag set on expiry wins over clear on read
         if (awu_expire) begin
            wakeup_flag <= 1'b1;
         end else if (bus_read & hit_ctrl) begin
            wakeup_flag <= 1'b0;
         end
      end
   end

   // gating enables come from flip-flops so they never glitch
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gate <= gates_at_reset;
      end else begin
         gate <= gates_for(next_state);
      end
   end

   assign wakeup_irq = wakeup_flag;
   assign in_active_halt = gate[4];
   assign timed_wakeup_halt = gate[5];
   assign in_plain_halt = gate[6];
   assign main_osc_enable = gate[3];
   assign cpu_clock_enable = gate[2];
   assign periph_clock_enable = gate[1];
   assign timer_clock_enable = gate[0];
   assign rc_capture_route = (state == st_run) & rc_measure_enable;
   assign rc_osc_enable = rc_capture_route | (state == st_timed);

endmodule
`default_nettype wire

// [sim/hmwc_far.sv]
// rc oscillator model on the far side of the wake-up prescaler
`timescale 1ns/1ps
`default_nettype none
module hmwc_far (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic rc_osc_enable,
   output logic rc_tick,
   output logic [15:0] tick_cnt
);
   logic [1:0] ph;
   // rc clock stands still while the oscillator is off
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ph <= 2'h0;
         rc_tick <= 1'b0;
         tick_cnt <= 16'h0000;
      end else begin
         ph <= rc_osc_enable ? ph + 2'h1 : 2'h0;
         rc_tick <= rc_osc_enable & (ph == 2'h2);
         tick_cnt <= tick_cnt + {15'h0000, rc_tick};
      end
   end
endmodule
`default_nettype wire

// [sim/hmwc_top_sva.sv]
// halt sequencing checker bound to the top ports
`timescale 1ns/1ps
`default_nettype none
`include "hmwc_regs.vh"
module hmwc_top_sva (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic halt_exec,
   input wire logic timebase_irq_enable,
   input wire logic overflow_irq_enable,
   input wire logic timer_clock_sel_hi,
   input wire logic timer_clock_sel_lo,
   input wire logic watchdog_active,
   input wire logic watchdog_halt_option,
   input wire logic halt_exit_irq,
   input wire logic wake_reset,
   input wire logic irq_mask_clear,
   input wire logic watchdog_reset,
   input wire logic resume_interrupt,
   input wire logic wakeup_irq,
   input wire logic main_osc_enable,
   input wire logic cpu_clock_enable,
   input wire logic periph_clock_enable,
   input wire logic timer_clock_enable,
   input wire logic rc_osc_enable,
   input wire logic in_active_halt,
   input wire logic timed_wakeup_halt,
   input wire logic in_plain_halt
);
   wire elig = timebase_irq_enable |
      (overflow_irq_enable & ~timer_clock_sel_hi & timer_clock_sel_lo);
   wire run_st = cpu_clock_enable & ~in_active_halt & ~timed_wakeup_halt & ~in_plain_halt;
   wire go = run_st & halt_exec;
   wire wd = watchdog_active & watchdog_halt_option;
   wire cs_acc = psel & penable & (paddr == `HMWC_ADDR_CTRL_STAT);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_active_entry: assert property (go & elig |=> in_active_halt & irq_mask_clear)
      else $error("active-halt entry wrong");
   a_active_wdog: assert property (go & elig |=> !watchdog_reset)
      else $error("watchdog reset from active-halt");
   a_active_wake: assert property (in_active_halt & halt_exit_irq & !wake_reset
      |=> resume_interrupt & run_st)
      else $error("active-halt interrupt wake late");
   a_active_clocks: assert property (in_active_halt |-> main_osc_enable & timer_clock_enable
      & !periph_clock_enable & !cpu_clock_enable)
      else $error("active-halt clocks wrong");
   a_timed_clocks: assert property (timed_wakeup_halt
      |-> !main_osc_enable & !cpu_clock_enable & rc_osc_enable)
      else $error("timed halt clocks wrong");
   a_wdog_reset: assert property (go & !elig & wd |=> watchdog_reset & !in_plain_halt)
      else $error("watchdog reset missing");
   a_halt_entry: assert property (go & !elig & !wd
      |=> (timed_wakeup_halt | in_plain_halt) & irq_mask_clear)
      else $error("halt entry wrong");
   a_flag_clear: assert property (cs_acc & !pwrite & !timed_wakeup_halt |=> !wakeup_irq)
      else $error("flag not cleared by read");
   a_status_zero: assert property (cs_acc |-> prdata[31:3] == 29'h0)
      else $error("reserved status bits set");
endmodule
bind hmwc_top hmwc_top_sva u_sva (.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .prdata,
   .halt_exec, .timebase_irq_enable, .overflow_irq_enable, .timer_clock_sel_hi,
   .timer_clock_sel_lo, .watchdog_active, .watchdog_halt_option, .halt_exit_irq,
   .wake_reset, .irq_mask_clear, .watchdog_reset, .resume_interrupt, .wakeup_irq,
   .main_osc_enable, .cpu_clock_enable, .periph_clock_enable, .timer_clock_enable,
   .rc_osc_enable, .in_active_halt, .timed_wakeup_halt, .in_plain_halt);
`default_nettype wire

// [sim/test_halt_mode_wakeup_control.sv]
// self-checking bench for the halt wake-up control
`timescale 1ns/1ps
`default_nettype none
`include "hmwc_regs.vh"
module test_halt_mode_wakeup_control;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, halt_exec = 1'b0;
   logic [31:0] pwdata = 32'h0, rd;
   logic timebase_irq_enable = 1'b0, overflow_irq_enable = 1'b0, timer_clock_sel_lo = 1'b0;
   logic watchdog_active = 1'b0, watchdog_halt_option = 1'b0, er;
   logic halt_exit_irq = 1'b0, wake_reset = 1'b0;
   logic timer_clock_sel_hi = 1'b0, stab_long_select = 1'b0, pll_enable_option = 1'b0;
   logic [15:0] b;
   wire [31:0] prdata;
   wire [15:0] tick_cnt;
   wire pready, pslverr, rc_tick, watchdog_reset, resume_interrupt, resume_reset_vector;
   wire wakeup_irq, rc_osc_enable, rc_capture_route, in_active_halt;
   wire timed_wakeup_halt, in_plain_halt;
   int fails = 0, num_checks = 0, n;
   hmwc_top u_dut (.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .halt_exec, .timebase_irq_enable, .overflow_irq_enable,
      .timer_clock_sel_hi, .timer_clock_sel_lo, .watchdog_active, .watchdog_halt_option,
      .pll_enable_option, .stab_long_select, .halt_exit_irq, .wake_reset, .rc_tick,
      .irq_mask_clear(), .watchdog_reset, .resume_interrupt, .resume_reset_vector, .wakeup_irq,
      .main_osc_enable(), .cpu_clock_enable(), .periph_clock_enable(), .timer_clock_enable(),
      .rc_osc_enable, .rc_capture_route, .in_active_halt, .timed_wakeup_halt, .in_plain_halt);
   hmwc_far u_far (.clk, .rst_b, .rc_osc_enable, .rc_tick, .tick_cnt);
   always #20 clk = ~clk;
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", s, e, g);
         fails++;
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
      if (k >= 50) begin
         fails++;
         conclude();
      end
   endtask
   task automatic halt;
      @(posedge clk);
      halt_exec <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      #1;
   endtask
   task automatic kick(input logic r);
      @(posedge clk);
      {wake_reset, halt_exit_irq} <= {r, ~r};
      @(posedge clk);
      {wake_reset, halt_exit_irq} <= 2'b00;
   endtask
   task automatic await(input int s);
      n = 0;
      #1;
      while (!(s == 0 ? resume_interrupt === 1'b1 : s == 1 ? resume_reset_vector === 1'b1
            : wakeup_irq === 1'b1) && n < 5000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 5000) begin
         fails++;
         conclude();
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      xfer(0, `HMWC_ADDR_PRESCALER, 0);
      chk("prescaler reset", 32'hff, rd);
      xfer(0, `HMWC_ADDR_CTRL_STAT, 0);
      chk("status reset", 32'h00, rd);
      xfer(0, 12'h12c, 0);
      chk("unmapped error", 1, er);
      xfer(1, `HMWC_ADDR_CTRL_STAT, 32'hff);
      xfer(0, `HMWC_ADDR_CTRL_STAT, 0);
      chk("status bits", 32'h03, rd);
      chk("capture route", 1, rc_capture_route);
      chk("rc enable", 1, rc_osc_enable);
      xfer(1, `HMWC_ADDR_PRESCALER, 0);
      xfer(0, `HMWC_ADDR_PRESCALER, 0);
      chk("prescaler zero", 32'hff, rd);
      xfer(1, `HMWC_ADDR_PRESCALER, 3);
      xfer(1, `HMWC_ADDR_CTRL_STAT, 1);
      $display("registers done");
      @(posedge clk);
      timebase_irq_enable <= 1'b1;
      halt();
      chk("active by timebase", 1, in_active_halt);
      kick(0);
      await(0);
      chk("irq wake delay", 0, n);
      @(posedge clk);
      {timebase_irq_enable, overflow_irq_enable, timer_clock_sel_lo} <= 3'b011;
      {watchdog_active, watchdog_halt_option} <= 2'b11;
      halt();
      chk("active by overflow", 1, in_active_halt);
      chk("no watchdog reset", 0, watchdog_reset);
      kick(1);
      await(1);
      chk("reset wake delay", 1, n >= 256 && n <= 258);
      @(posedge clk);
      timer_clock_sel_lo <= 1'b0;
      halt();
      chk("watchdog reset", 1, watchdog_reset);
      @(posedge clk);
      {watchdog_active, watchdog_halt_option} <= 2'b00;
      halt();
      chk("timed halt", 1, timed_wakeup_halt);
      b = tick_cnt;
      await(2);
      chk("rc ticks", 192, tick_cnt - b);
      await(0);
      chk("expiry wake delay", 1, n >= 256 && n <= 258);
      xfer(0, `HMWC_ADDR_CTRL_STAT, 0);
      chk("flag set", 32'h05, rd);
      xfer(1, `HMWC_ADDR_CTRL_STAT, 0);
      xfer(0, `HMWC_ADDR_CTRL_STAT, 0);
      chk("flag cleared", 32'h00, rd);
      halt();
      chk("plain halt", 1, in_plain_halt);
      kick(0);
      await(0);
      chk("plain wake delay", 1, n >= 256 && n <= 258);
      @(posedge clk);
      {timer_clock_sel_hi, timer_clock_sel_lo, stab_long_select, pll_enable_option} <= 4'hf;
      halt();
      chk("overflow with clock 11", 1, in_plain_halt);
      kick(1);
      await(1);
      chk("long delay with pll", 1, n >= 4121 && n <= 4123);
      $display("halt modes done");
      conclude();
   end
endmodule
`default_nettype wire
